// File: include/arr_pkg.sv
// Package for the converter result and alarm register block.
// Assumes a classic Wishbone slave with 32-bit data, one register per aligned word.
package arr_pkg;
    // Printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] ARR_IDX_AUX_LOW     = 8'h49;
    localparam logic [7:0] ARR_IDX_VIN_HIGH    = 8'h4A;
    localparam logic [7:0] ARR_IDX_VIN_LOW     = 8'h4B;
    localparam logic [7:0] ARR_IDX_RAIL_HIGH   = 8'h4C;
    localparam logic [7:0] ARR_IDX_RAIL_LOW    = 8'h4D;
    localparam logic [7:0] ARR_IDX_IIN_HIGH    = 8'h4E;
    localparam logic [7:0] ARR_IDX_IIN_LOW     = 8'h4F;
    localparam logic [7:0] ARR_IDX_AL1_HIGH    = 8'h52;
    localparam logic [7:0] ARR_IDX_AL1_LOW     = 8'h53;
    localparam logic [7:0] ARR_IDX_AL2_HIGH    = 8'h54;
    localparam logic [7:0] ARR_IDX_AL2_LOW     = 8'h55;
    localparam logic [7:0] ARR_IDX_AL3_HIGH    = 8'h56;
    // Registers without printed offsets
    localparam logic [7:0] ARR_IDX_CHAN_SEL    = 8'h60;
    localparam logic [7:0] ARR_IDX_IRQ_STATUS  = 8'h61;
    localparam logic [7:0] ARR_IDX_IRQ_MASK    = 8'h62;
    // Reset values
    localparam logic [7:0] ARR_RST_AL1_HIGH    = 8'h23;
    localparam logic [7:0] ARR_RST_AL1_LOW     = 8'h20;
    localparam logic [7:0] ARR_RST_AL2_HIGH    = 8'h38;
    localparam logic [7:0] ARR_RST_AL2_LOW     = 8'h90;
    localparam logic [7:0] ARR_RST_AL3_HIGH    = 8'h00;
    localparam logic [2:0] ARR_RST_SEL1        = 3'h0;
    localparam logic [2:0] ARR_RST_SEL2        = 3'h2;
    localparam logic [2:0] ARR_RST_SEL3        = 3'h0;
    // Field layout of a low threshold register
    localparam int         ARR_POL_BIT         = 3;
    localparam logic [7:0] ARR_LOW_WMASK       = 8'hF8;
    localparam int         ARR_SEL_W           = 3;
    // Channel codes
    localparam logic [2:0] ARR_CH_OFF          = 3'h0;
    localparam logic [2:0] ARR_CH_AUX          = 3'h1;
    localparam logic [2:0] ARR_CH_THERM        = 3'h2;
    localparam logic [2:0] ARR_CH_VBAT         = 3'h3;
    localparam logic [2:0] ARR_CH_CHG          = 3'h4;
    localparam logic [2:0] ARR_CH_VIN          = 3'h5;
    localparam logic [2:0] ARR_CH_RAIL         = 3'h6;
    localparam logic [2:0] ARR_CH_IIN          = 3'h7;
    localparam int         ARR_NCOMP           = 3;
endpackage : arr_pkg

// File: core/arr_regs.sv
// Converter result registers and three alarm comparators behind classic Wishbone.
// Assumes results arrive as 16-bit words with one-cycle store strobes from the converter.
// Assumes one clock with synchronous inputs and a master that holds each request until ack.
// Result registers carry no reset, so software must not trust them before the first store.
//
// Operation
// - The auxiliary input result low byte reads in bits 7-0 at index 0x49 and has no defined reset.
// - The input voltage result is 16 bits, high byte at 0x4A and low byte at 0x4B, no defined reset.
// - The system rail result is 16 bits, high byte at 0x4C and low byte at 0x4D, no defined reset.
// - The input current result is 16 bits, high byte at 0x4E and low byte at 0x4F, no defined reset.
// - Each threshold is 12 bits: high register bits 7-0 above low register bits 7-4.
// - With polarity clear, a comparator flags and interrupts when its measurement falls below threshold.
// - With polarity set, a comparator flags and interrupts when its measurement rises above threshold.
// - Comparator one resets to threshold high 0x23, low nibble 0010, below-threshold polarity.
// - Comparator two resets to threshold high 0x38, low nibble 1001.
// - Comparators one and two each have their own polarity at bit 3 of their low register, reset zero, bits 2-0 reserved.
// - A 3-bit selector picks the channel; code 0 disables, codes 1-7 pick aux, therm, vbat, charge, vin, rail, iin.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
module arr_regs
    import arr_pkg::*;
#(
    parameter int RES_W = 16
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [9:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // Converter results, one strobe per channel code 1..7
    input  wire logic [RES_W-1:0]  aux_input_result_i,
    input  wire logic [RES_W-1:0]  thermistor_sense_result_i,
    input  wire logic [RES_W-1:0]  battery_voltage_result_i,
    input  wire logic [RES_W-1:0]  charge_current_result_i,
    input  wire logic [RES_W-1:0]  input_voltage_result_i,
    input  wire logic [RES_W-1:0]  system_rail_result_i,
    input  wire logic [RES_W-1:0]  input_current_result_i,
    input  wire logic [7:1]        result_valid_i,
    // Alarm outputs
    output logic [ARR_NCOMP-1:0]   alarm_flag_o,
    output logic                   irq_o
);

    // Result holding registers; these carry no reset
    logic [RES_W-1:0]     res_mux [0:7];
    logic [RES_W-1:0]     aux_reg;
    logic [RES_W-1:0]     vin_reg;
    logic [RES_W-1:0]     rail_reg;
    logic [RES_W-1:0]     iin_reg;

    // Alarm configuration
    logic [7:0]           thr_high_reg [0:ARR_NCOMP-1];
    logic [7:0]           thr_low_reg  [0:ARR_NCOMP-1];
    logic [ARR_SEL_W-1:0] sel_reg      [0:ARR_NCOMP-1];

    // Alarm status
    logic [ARR_NCOMP-1:0] status_reg;
    logic [ARR_NCOMP-1:0] mask_reg;
    logic [ARR_NCOMP-1:0] hit;
    logic [ARR_NCOMP-1:0] clr_mask;

    // Bus decode
    logic [7:0]           idx;
    logic                 wr_lane0;
    logic                 req;
    logic [7:0]           wbyte;
    logic [31:0]          rdata_next;
    logic                 wr_status;
    logic                 wr_mask;
    logic                 wr_sel;

    // Field geometry of the word address and of a threshold
    localparam int IDX_MSB = 9;
    localparam int IDX_LSB = 2;
    localparam int THR_W   = 12;
    localparam int NIB_MSB = 7;
    localparam int NIB_LSB = 4;

    // The two low address bits are ignored since every register is word aligned
    assign idx      = adr_i[IDX_MSB:IDX_LSB];
    // A request is not taken again in its ack cycle, so a strobe still up in that cycle cannot repeat a write
    assign req      = cyc_i & stb_i & ~ack_o;
    // Every field except the third selector (bits 10-8, lane 1) lives in byte lane 0, and only lane 0's enable gates a write
    assign wr_lane0 = req & we_i & sel_i[0];
    assign wbyte    = dat_i[7:0];

    // Decoded write strobes for the control registers
    assign wr_status = wr_lane0 && (idx == ARR_IDX_IRQ_STATUS);
    assign wr_mask   = wr_lane0 && (idx == ARR_IDX_IRQ_MASK);
    assign wr_sel    = wr_lane0 && (idx == ARR_IDX_CHAN_SEL);
    assign clr_mask  = wr_status ? wbyte[ARR_NCOMP-1:0] : '0;

    // Channel table indexed by selector code; code zero reads as an idle channel
    // Codes one to seven follow the selector order
    assign res_mux[0] = '0;
    assign res_mux[1] = aux_input_result_i;
    assign res_mux[2] = thermistor_sense_result_i;
    assign res_mux[3] = battery_voltage_result_i;
    assign res_mux[4] = charge_current_result_i;
    assign res_mux[5] = input_voltage_result_i;
    assign res_mux[6] = system_rail_result_i;
    assign res_mux[7] = input_current_result_i;

    // Auxiliary result; only its low byte is mapped in this block
    // A converter store beats a software write in the same cycle so a fresh sample is never lost
    always_ff @(posedge clk_i) begin
        if (result_valid_i[ARR_CH_AUX]) begin
            aux_reg <= aux_input_result_i;
        end else if (wr_lane0 && idx == ARR_IDX_AUX_LOW) begin
            aux_reg[7:0] <= wbyte;
        end
    end

    // Input voltage result, high byte then low byte at consecutive indices
    always_ff @(posedge clk_i) begin
        if (result_valid_i[ARR_CH_VIN]) begin
            vin_reg <= input_voltage_result_i;
        end else if (wr_lane0 && idx == ARR_IDX_VIN_HIGH) begin
            vin_reg[15:8] <= wbyte;
        end else if (wr_lane0 && idx == ARR_IDX_VIN_LOW) begin
            vin_reg[7:0] <= wbyte;
        end
    end

    // System rail result, both bytes latched together on a store
    always_ff @(posedge clk_i) begin
        if (result_valid_i[ARR_CH_RAIL]) begin
            rail_reg <= system_rail_result_i;
        end else if (wr_lane0 && idx == ARR_IDX_RAIL_HIGH) begin
            rail_reg[15:8] <= wbyte;
        end else if (wr_lane0 && idx == ARR_IDX_RAIL_LOW) begin
            rail_reg[7:0] <= wbyte;
        end
    end

    // Input current result; no read lock, so a store between two byte reads can tear the pair
    always_ff @(posedge clk_i) begin
        if (result_valid_i[ARR_CH_IIN]) begin
            iin_reg <= input_current_result_i;
        end else if (wr_lane0 && idx == ARR_IDX_IIN_HIGH) begin
            iin_reg[15:8] <= wbyte;
        end else if (wr_lane0 && idx == ARR_IDX_IIN_LOW) begin
            iin_reg[7:0] <= wbyte;
        end
    end

    // Threshold high bytes; comparator three has only its high byte in this map
    // A new threshold takes effect at the next store, never on a result already compared
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_high_reg[0] <= ARR_RST_AL1_HIGH;
            thr_high_reg[1] <= ARR_RST_AL2_HIGH;
            thr_high_reg[2] <= ARR_RST_AL3_HIGH;
        end else if (wr_lane0) begin
            case (idx)
                ARR_IDX_AL1_HIGH: begin
                    thr_high_reg[0] <= wbyte;
                end
                ARR_IDX_AL2_HIGH: begin
                    thr_high_reg[1] <= wbyte;
                end
                ARR_IDX_AL3_HIGH: begin
                    thr_high_reg[2] <= wbyte;
                end
                default: begin
                end
            endcase
        end
    end

    // Threshold low bytes with polarity; reserved bits are dropped on write so they read zero
    // Comparator three has no low register here, so its nibble and polarity stay zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_low_reg[0] <= ARR_RST_AL1_LOW;
            thr_low_reg[1] <= ARR_RST_AL2_LOW;
            thr_low_reg[2] <= '0;
        end else if (wr_lane0) begin
            case (idx)
                ARR_IDX_AL1_LOW: begin
                    thr_low_reg[0] <= wbyte & ARR_LOW_WMASK;
                end
                ARR_IDX_AL2_LOW: begin
                    thr_low_reg[1] <= wbyte & ARR_LOW_WMASK;
                end
                default: begin
                end
            endcase
        end
    end

    // Channel selectors, one 3-bit field per comparator in a shared register
    // Fields sit on nibble boundaries so software can write them as hex digits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_reg[0] <= ARR_RST_SEL1;
            sel_reg[1] <= ARR_RST_SEL2;
            sel_reg[2] <= ARR_RST_SEL3;
        end else if (wr_sel) begin
            sel_reg[0] <= dat_i[2:0];
            sel_reg[1] <= dat_i[6:4];
            sel_reg[2] <= dat_i[10:8];
        end
    end

    // One comparator per alarm, evaluated on each store of its selected channel
    for (genvar c = 0; c < ARR_NCOMP; c++) begin : g_cmp
        logic [THR_W-1:0] thr;
        logic [RES_W-1:0] meas;
        logic             pol;
        logic             enabled;
        logic             fresh;
        logic             below;
        logic             above;
        // Threshold assembled from the high byte and the upper nibble of the low byte
        assign thr     = {thr_high_reg[c], thr_low_reg[c][NIB_MSB:NIB_LSB]};
        assign pol     = thr_low_reg[c][ARR_POL_BIT];
        assign meas    = res_mux[sel_reg[c]];
        // Code zero parks the comparator; the guard also keeps the strobe index in range
        assign enabled = (sel_reg[c] != ARR_CH_OFF);
        assign fresh   = enabled && result_valid_i[sel_reg[c]];
        // Top bits of the result against the threshold, strict on both sides
        assign below   = (meas[RES_W-1 -: THR_W] < thr);
        assign above   = (meas[RES_W-1 -: THR_W] > thr);
        assign hit[c]  = fresh && (pol ? above : below);
    end

    // Sticky status, write one to clear
    // Set beats clear so an event landing on the clearing write is never lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~clr_mask) | hit;
        end
    end

    // Interrupt mask, same layout as the status register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= '0;
        end else if (wr_mask) begin
            mask_reg <= wbyte[ARR_NCOMP-1:0];
        end
    end

    // Flag outputs mirror status one cycle later so every output leaves a flip-flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_flag_o <= '0;
        end else begin
            alarm_flag_o <= status_reg;
        end
    end

    // Level interrupt, high while any unmasked flag is set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_reg & mask_reg);
        end
    end

    // Read mux; unmapped indices read zero
    always_comb begin
        rdata_next = '0;
        case (idx)
            // Result bytes
            ARR_IDX_AUX_LOW: begin
                rdata_next[7:0] = aux_reg[7:0];
            end
            ARR_IDX_VIN_HIGH: begin
                rdata_next[7:0] = vin_reg[15:8];
            end
            ARR_IDX_VIN_LOW: begin
                rdata_next[7:0] = vin_reg[7:0];
            end
            ARR_IDX_RAIL_HIGH: begin
                rdata_next[7:0] = rail_reg[15:8];
            end
            ARR_IDX_RAIL_LOW: begin
                rdata_next[7:0] = rail_reg[7:0];
            end
            ARR_IDX_IIN_HIGH: begin
                rdata_next[7:0] = iin_reg[15:8];
            end
            ARR_IDX_IIN_LOW: begin
                rdata_next[7:0] = iin_reg[7:0];
            end
            // Thresholds
            ARR_IDX_AL1_HIGH: begin
                rdata_next[7:0] = thr_high_reg[0];
            end
            ARR_IDX_AL1_LOW: begin
                rdata_next[7:0] = thr_low_reg[0];
            end
            ARR_IDX_AL2_HIGH: begin
                rdata_next[7:0] = thr_high_reg[1];
            end
            ARR_IDX_AL2_LOW: begin
                rdata_next[7:0] = thr_low_reg[1];
            end
            ARR_IDX_AL3_HIGH: begin
                rdata_next[7:0] = thr_high_reg[2];
            end
            // Control
            ARR_IDX_CHAN_SEL: begin
                rdata_next[2:0]  = sel_reg[0];
                rdata_next[6:4]  = sel_reg[1];
                rdata_next[10:8] = sel_reg[2];
            end
            ARR_IDX_IRQ_STATUS: begin
                rdata_next[ARR_NCOMP-1:0] = status_reg;
            end
            ARR_IDX_IRQ_MASK: begin
                rdata_next[ARR_NCOMP-1:0] = mask_reg;
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    // Ack one cycle after the request, dropped the cycle after even if the strobe stays up
    // Fixed single wait state keeps the slave free of any counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // Read data only alongside ack; zero between cycles keeps the bus quiet
    // Writes also return the addressed value, which a master may ignore
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else begin
            dat_o <= req ? rdata_next : '0;
        end
    end

endmodule : arr_regs

// File: tb/arr_regs_sva.sv
// Checker for the result and alarm register block.
// Assumes it is bound to arr_regs and sees only that module's ports.
`timescale 1ns/1ns
module arr_regs_sva
    import arr_pkg::*;
(
    // Clock, reset and bus
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 cyc_i,
    input wire logic                 stb_i,
    input wire logic                 we_i,
    input wire logic [9:0]           adr_i,
    input wire logic [31:0]          dat_o,
    input wire logic                 ack_o,
    // Converter strobes and alarms
    input wire logic [7:1]           result_valid_i,
    input wire logic [ARR_NCOMP-1:0] alarm_flag_o,
    input wire logic                 irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Any write may clear status, so stickiness is only claimed while no write is up
    wire logic wr = cyc_i && stb_i && we_i;
    property p_ack_rise; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_rise: assert property (p_ack_rise) else $error("ack missing after request");
    property p_ack_fall; ack_o |=> !ack_o; endproperty
    a_ack_fall: assert property (p_ack_fall) else $error("ack longer than one cycle");
    property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_resv; ack_o && !$past(we_i) && $past(adr_i[9:2]) == ARR_IDX_AL1_LOW |-> dat_o[2:0] == 3'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits read nonzero");
    property p_byte; ack_o && !$past(we_i) && $past(adr_i[9:2]) < ARR_IDX_CHAN_SEL |-> dat_o[31:8] == 24'h0; endproperty
    a_byte: assert property (p_byte) else $error("byte register wider than 8 bits");
    // Strobe sampled at N sets status at N and the flag output at N+1, so a rise looks two samples back
    property p_cause; (alarm_flag_o & ~$past(alarm_flag_o)) != 3'h0 |-> $past(result_valid_i, 2) != 7'h0; endproperty
    a_cause: assert property (p_cause) else $error("flag set without a stored result");
    property p_sticky; !wr |=> (alarm_flag_o & $past(alarm_flag_o)) == $past(alarm_flag_o); endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without a clear");
    property p_irq; irq_o |-> alarm_flag_o != 3'h0; endproperty
    a_irq: assert property (p_irq) else $error("interrupt without a flag");
endmodule : arr_regs_sva

bind arr_regs arr_regs_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .result_valid_i(result_valid_i), .alarm_flag_o(alarm_flag_o),
    .irq_o(irq_o));

// File: tb/adc_result_and_alarm_regs_test.sv
// Self-checking bench for the result and alarm register block.
// Assumes one 125 MHz clock and a Wishbone master modelled here.
`timescale 1ns/1ns
module adc_result_and_alarm_regs_test import arr_pkg::*;;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, irq_o, ack_o;
    logic [9:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic [15:0] res [1:7];
    logic [15:0] v;
    logic [7:1]  rv;
    logic [2:0]  flag, fl, msk;
    logic [11:0] thr [0:1];
    logic [2:0]  sel [0:1];
    logic        pol [0:1];
    int          failures, checked, cycles;
    logic [7:0]  ri [8] = '{8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h60, 8'h61, 8'h62};
    logic [31:0] re [8] = '{32'h23, 32'h20, 32'h38, 32'h90, 32'h0, 32'h20, 32'h0, 32'h0};
    logic [7:0]  li [4] = '{8'h49, 8'h4B, 8'h4D, 8'h4F};
    int          ci [4] = '{1, 5, 6, 7};
    arr_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .aux_input_result_i(res[1]),
        .thermistor_sense_result_i(res[2]), .battery_voltage_result_i(res[3]), .charge_current_result_i(res[4]),
        .input_voltage_result_i(res[5]), .system_rail_result_i(res[6]), .input_current_result_i(res[7]),
        .result_valid_i(rv), .alarm_flag_o(flag), .irq_o(irq_o));
    // Free-running clock
    always #4 clk_i = ~clk_i;
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One classic cycle; request held until ack is sampled
    task wb(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, idx, 2'b00, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask : wb
    // Store one result, update the alarm model, compare once flags have landed
    task store(input int c, input logic [15:0] d);
        @(posedge clk_i);
        res[c] <= d;
        rv[c] <= 1'b1;
        @(posedge clk_i);
        rv <= 7'h0;
        for (int i = 0; i < 2; i++) if (sel[i] == c && (pol[i] ? d[15:4] > thr[i] : d[15:4] < thr[i])) fl[i] = 1'b1;
        repeat (2) @(posedge clk_i);
        chk("alarm flags", 32'(flag), 32'(fl));
        chk("irq", 32'(irq_o), 32'(|(fl & msk)));
    endtask : store
    task complete_run();
        if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // Main sequence
    initial begin
        {clk_i, rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, rv, fl, msk} = {2'b01, 58'h0};
        {sel_i, cycles, failures, checked} = {4'hF, 96'h0};
        {thr[0], thr[1], pol[0], pol[1], sel[0], sel[1]} = {12'h232, 12'h389, 2'b00, ARR_CH_OFF, ARR_CH_THERM};
        foreach (res[i]) res[i] = 16'h0;
        void'($urandom(32'hC88A8536));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, ri[i], 32'h0, q);
            chk("reset value", q, re[i]);
        end
        wb(1'b1, 8'h70, 32'hFF, q);
        wb(1'b0, 8'h70, 32'h0, q);
        chk("unmapped read", q, 32'h0);
        v = 16'($urandom);
        wb(1'b1, ARR_IDX_AL2_HIGH, {24'h0, v[15:8]}, q);
        wb(1'b1, ARR_IDX_AL2_LOW, {24'h0, v[7:0]}, q);
        {thr[1], pol[1]} = {v[15:4], v[3]};
        wb(1'b0, ARR_IDX_AL2_LOW, 32'h0, q);
        chk("threshold low", q, {24'h0, v[7:0] & ARR_LOW_WMASK});
        for (int i = 1; i <= 7; i++) store(i, 16'($urandom));
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, li[i], 32'h0, q);
            chk("result low", q, {24'h0, res[ci[i]][7:0]});
            if (i > 0) wb(1'b0, li[i] - 8'h1, 32'h0, q);
            if (i > 0) chk("result high", q, {24'h0, res[ci[i]][15:8]});
        end
        wb(1'b1, ARR_IDX_IRQ_STATUS, 32'h7, q);
        wb(1'b1, ARR_IDX_IRQ_MASK, 32'h7, q);
        wb(1'b1, ARR_IDX_CHAN_SEL, 32'h25, q);
        {fl, msk, sel[0], sel[1]} = {3'h0, 3'h7, ARR_CH_VIN, ARR_CH_THERM};
        store(5, 16'h2320);
        store(5, 16'h2310);
        store(5, 16'hFFF0);
        wb(1'b1, ARR_IDX_AL1_LOW, 32'h28, q);
        pol[0] = 1'b1;
        for (int c = 1; c <= 7; c++) begin
            wb(1'b1, ARR_IDX_CHAN_SEL, 32'(c), q);
            wb(1'b1, ARR_IDX_IRQ_STATUS, 32'h7, q);
            {fl, sel[0], sel[1]} = {3'h0, 3'(c), ARR_CH_OFF};
            store(c % 7 + 1, 16'hFFF0);
            store(c, 16'h2320);
            store(c, 16'h2330);
            wb(1'b0, ARR_IDX_IRQ_STATUS, 32'h0, q);
            chk("status", q, 32'(fl));
        end
        wb(1'b1, ARR_IDX_IRQ_MASK, 32'h0, q);
        msk = 3'h0;
        store(7, 16'h0000);
        wb(1'b1, ARR_IDX_CHAN_SEL, 32'h0, q);
        wb(1'b1, ARR_IDX_IRQ_STATUS, 32'h7, q);
        {fl, sel[0]} = {3'h0, ARR_CH_OFF};
        store(7, 16'hFFF0);
        complete_run();
    end
endmodule : adc_result_and_alarm_regs_test
